// ---- pkg/phh_pkg.sv ----
// Constants, types and configuration layout of the pulse height histogrammer
// Function
// - Shaping pipeline takes every sample without stalling, except in the cycle a rise or flat change restarts it, producing a shaped pulse
// - Peak of each shaped pulse is detected and reported exactly once
// - Shaped waveform is offered on a diagnostic output nothing else depends on
// - Pile-up rejection and risetime discrimination discard badly measured peaks
// - Each accepted peak increments the saturating histogram counter addressed by the upper bits of its peak value unless ST_RUN ends as PEAK_ACCEPT rises
// - Every histogram counter is three bytes wide
// - Host can start and stop processing and clear the whole histogram
// - Acquisition is locked out during preamplifier reset and its recovery
// - Peaking time and other shaping settings come from the host
// - Dead time and pile-up interval is rise plus a fifth of rise plus flat top
// - With rejection on, a pair between pair resolution and interval drops only the next peak to end after the second trigger
package phh_pkg;
	localparam int SMP_W = 12;
	localparam int SHP_W = SMP_W + 6;
	localparam int CNT_W = 24;
	localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
	localparam int DLY_AW = 7;
	localparam int GAP_W = 8;
	localparam int RT_W = 6;
	localparam int RC_W = 13;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SAMPLE_RATE_MHZ = 20;
	localparam int CLK_MHZ = 40;
	localparam int CLK_PER_SMP = CLK_MHZ / SAMPLE_RATE_MHZ;
	localparam int JIT_DIV = 5;
	localparam int PAIR_RES_NS = 600;
	localparam int PAIR_RES_CYC = (PAIR_RES_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RECOV_CYC_DEF = 400;
	localparam int RUN_RST = 0;

	typedef struct packed {
		logic [4:0] rise;
		logic [4:0] flat;
		logic pur_en;
		logic [RT_W-1:0] rtd_max;
		logic [SHP_W-2:0] thresh;
		logic [SMP_W-1:0] fast_thresh;
	} phh_cfg_t;

	typedef struct packed {
		logic start;
		logic stop;
		logic clear;
	} phh_cmd_t;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_CLEAR} phh_state_t;
endpackage : phh_pkg

// ---- rtl/phh_top.sv ----
// Shaper, peak detector, pulse selection and histogram memory
`timescale 1ns/1ps
module phh_top #(
	parameter int ADDR_W = 10,
	parameter int RECOV_CYC = phh_pkg::RECOV_CYC_DEF
) (
	// Clock, reset, enable
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	// Converter stream and preamplifier reset
	input wire logic ADC_VALID,
	input wire logic [phh_pkg::SMP_W-1:0] ADC_DATA,
	input wire logic PREAMP_RESET,
	// Host control
	input wire phh_pkg::phh_cfg_t CFG,
	input wire phh_pkg::phh_cmd_t CMD,
	input wire logic RD_EN,
	input wire logic [ADDR_W-1:0] RD_ADDR,
	// Results
	output logic [phh_pkg::SHP_W-1:0] SHAPED,
	output logic PEAK_VALID,
	output logic PEAK_ACCEPT,
	output logic [phh_pkg::SHP_W-1:0] PEAK_VAL,
	output logic RUNNING,
	output logic CLEARING,
	output logic INHIBIT,
	output logic RD_VALID,
	output logic [phh_pkg::CNT_W-1:0] RD_DATA
);
	localparam int SW = phh_pkg::SHP_W;
	localparam int XW = SW - phh_pkg::SMP_W;
	localparam logic [ADDR_W-1:0] LAST_A = '1;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN || !CE);

	// Preamplifier reset lockout
	logic s1_r, s2_r, s3_r, prst_r, prst_nxt, inh_r, inh_nxt;
	logic [phh_pkg::RC_W-1:0] rc_r, rc_nxt;
	always_comb begin
		prst_nxt = (s2_r == s3_r) ? s3_r : prst_r;
		rc_nxt = rc_r;
		if (prst_nxt)
			rc_nxt = phh_pkg::RC_W'(RECOV_CYC);
		else if (rc_r != '0)
			rc_nxt = rc_r - 1'b1;
		inh_nxt = prst_nxt || (rc_nxt != '0);
	end
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			{s1_r, s2_r, s3_r, prst_r, inh_r} <= 5'h00;
			rc_r <= '0;
		end else if (CE) begin
			s1_r <= PREAMP_RESET;
			s2_r <= s1_r;
			s3_r <= s2_r;
			prst_r <= prst_nxt;
			rc_r <= rc_nxt;
			inh_r <= inh_nxt;
		end
	end

	// Trapezoidal shaper and fast channel
	logic [phh_pkg::SMP_W-1:0] dly [2**phh_pkg::DLY_AW];
	logic [phh_pkg::DLY_AW-1:0] wp_r, wp_nxt, l_len, a_k, a_l, a_kl, a_f;
	logic signed [SW-1:0] acc_r, acc_nxt, xs, fd;
	logic [9:0] cfgq_r;
	logic fhi_r, fhi_nxt, trig;
	function automatic logic signed [SW-1:0] ext(
		input logic [phh_pkg::SMP_W-1:0] v);
		ext = signed'({{XW{1'b0}}, v});
	endfunction : ext
	always_comb begin
		l_len = phh_pkg::DLY_AW'(CFG.rise) + phh_pkg::DLY_AW'(CFG.flat);
		a_k = wp_r - phh_pkg::DLY_AW'(CFG.rise);
		a_l = wp_r - l_len;
		a_kl = a_l - phh_pkg::DLY_AW'(CFG.rise);
		a_f = wp_r - 7'h02;
		xs = ext(ADC_DATA);
		fd = xs - ext(dly[a_f]);
		acc_nxt = acc_r;
		wp_nxt = wp_r;
		fhi_nxt = fhi_r;
		if (cfgq_r != {CFG.rise, CFG.flat}) begin
			acc_nxt = '0;
		end else if (ADC_VALID) begin
			acc_nxt = acc_r + xs - ext(dly[a_k]) - ext(dly[a_l])
				+ ext(dly[a_kl]);
			wp_nxt = wp_r + 1'b1;
		end
		if (ADC_VALID)
			fhi_nxt = fd > ext(CFG.fast_thresh);
		trig = ADC_VALID && fhi_nxt && !fhi_r;
	end
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			acc_r <= '0;
			wp_r <= '0;
			fhi_r <= 1'b0;
			cfgq_r <= '0;
			for (int i = 0; i < 2**phh_pkg::DLY_AW; i++)
				dly[i] <= '0;
		end else if (CE) begin
			acc_r <= acc_nxt;
			wp_r <= wp_nxt;
			fhi_r <= fhi_nxt;
			cfgq_r <= {CFG.rise, CFG.flat};
			if (ADC_VALID)
				dly[wp_r] <= ADC_DATA;
		end
	end
	assign SHAPED = acc_r;

	p_cfg: assert property ($changed({CFG.rise, CFG.flat}) |=> acc_r == '0)
		else $error("shaper not restarted on new shaping settings");

	// Peak detection, pile-up and risetime selection
	localparam int GAP_W_L = phh_pkg::GAP_W;
	logic [GAP_W_L-1:0] gap_r, gap_nxt, ivl;
	logic in_r, in_nxt, pu_r, pu_nxt, ih_r, ih_nxt, above, end_p, pu_hit;
	logic rtd_bad, pv_r, pv_nxt, pa_r, pa_nxt;
	logic [phh_pkg::RT_W-1:0] rt_r, rt_nxt;
	logic signed [SW-1:0] pk_r, pk_nxt, pkv_r, pkv_nxt;
	logic run_r;
	always_comb begin
		ivl = GAP_W_L'((CFG.rise + CFG.rise / phh_pkg::JIT_DIV + CFG.flat)
			* phh_pkg::CLK_PER_SMP);
		pu_hit = trig && CFG.pur_en && (gap_r > phh_pkg::PAIR_RES_CYC)
			&& (gap_r < ivl);
		gap_nxt = trig ? '0 : ((gap_r == '1) ? gap_r : gap_r + 1'b1);
		above = acc_r > signed'({1'b0, CFG.thresh});
		end_p = in_r && !above;
		rtd_bad = (CFG.rtd_max != '0) && (rt_r > CFG.rtd_max);
		in_nxt = above;
		pk_nxt = pk_r;
		rt_nxt = rt_r;
		ih_nxt = ih_r || inh_r;
		pu_nxt = pu_r;
		if (!in_r && above) begin
			pk_nxt = acc_r;
			rt_nxt = '0;
			ih_nxt = inh_r;
		end else if (in_r && acc_r > pk_r) begin
			pk_nxt = acc_r;
			rt_nxt = (rt_r == '1) ? rt_r : rt_r + 1'b1;
		end
		if (end_p)
			pu_nxt = 1'b0;
		if (pu_hit)
			pu_nxt = 1'b1;
		pv_nxt = end_p;
		pa_nxt = end_p && run_r && !pu_r && !ih_r && !inh_r
			&& !rtd_bad;
		pkv_nxt = end_p ? pk_r : pkv_r;
	end
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			gap_r <= '1;
			{in_r, pu_r, ih_r, pv_r, pa_r} <= 5'h00;
			rt_r <= '0;
			pk_r <= '0;
			pkv_r <= '0;
		end else if (CE) begin
			gap_r <= gap_nxt;
			in_r <= in_nxt;
			pu_r <= pu_nxt;
			ih_r <= ih_nxt;
			pv_r <= pv_nxt;
			pa_r <= pa_nxt;
			rt_r <= rt_nxt;
			pk_r <= pk_nxt;
			pkv_r <= pkv_nxt;
		end
	end
	assign PEAK_VALID = pv_r;
	assign PEAK_ACCEPT = pa_r;
	assign PEAK_VAL = pkv_r;

	p_one_peak: assert property (pv_r |=> !pv_r)
		else $error("peak reported twice for one pulse");
	p_pur: assert property (end_p && pu_r |=> pv_r && !pa_r)
		else $error("piled-up pulse accepted");
	p_pur_set: assert property (pu_hit |=> pu_r)
		else $error("pair inside interval not flagged");
	p_rtd: assert property (end_p && rtd_bad |=> !pa_r)
		else $error("slow-rising pulse accepted");
	p_inh: assert property (end_p && (ih_r || inh_r) |=> !pa_r)
		else $error("pulse accepted during preamp reset");

	// Run control and histogram memory
	logic [phh_pkg::CNT_W-1:0] mem [2**ADDR_W];
	phh_pkg::phh_state_t st_r, st_nxt;
	logic [ADDR_W-1:0] clr_a_r, clr_a_nxt, ha_r, ha_nxt, ha2_r, wr_a;
	logic hv_r, hv_nxt, hv2_r, wr_en, run_nxt, clr_r, rdv_r;
	logic [phh_pkg::CNT_W-1:0] rq_r, rq_nxt, wr_d, rdd_r, rdd_nxt;
	always_comb begin
		st_nxt = st_r;
		clr_a_nxt = clr_a_r;
		case (st_r)
			phh_pkg::ST_CLEAR: begin
				clr_a_nxt = clr_a_r + 1'b1;
				if (clr_a_r == LAST_A)
					st_nxt = phh_pkg::ST_IDLE;
			end
			phh_pkg::ST_RUN: begin
				if (CMD.clear)
					st_nxt = phh_pkg::ST_CLEAR;
				else if (CMD.stop)
					st_nxt = phh_pkg::ST_IDLE;
			end
			phh_pkg::ST_IDLE: begin
				if (CMD.clear)
					st_nxt = phh_pkg::ST_CLEAR;
				else if (CMD.start && !CMD.stop)
					st_nxt = phh_pkg::ST_RUN;
			end
			default: st_nxt = phh_pkg::ST_IDLE;
		endcase
		if (st_nxt == phh_pkg::ST_CLEAR && st_r != phh_pkg::ST_CLEAR)
			clr_a_nxt = '0;
		run_nxt = (st_nxt == phh_pkg::ST_RUN);
		// Pulses are far apart, so the read-modify-write never overlaps
		hv_nxt = pa_r && (st_r == phh_pkg::ST_RUN);
		ha_nxt = pkv_r[SW-2 -: ADDR_W];
		rq_nxt = mem[ha_r];
		wr_en = (st_r == phh_pkg::ST_CLEAR) || hv2_r;
		wr_a = (st_r == phh_pkg::ST_CLEAR) ? clr_a_r : ha2_r;
		if (st_r == phh_pkg::ST_CLEAR)
			wr_d = '0;
		else if (rq_r == phh_pkg::CNT_MAX)
			wr_d = rq_r;
		else
			wr_d = rq_r + 1'b1;
		rdd_nxt = RD_EN ? mem[RD_ADDR] : rdd_r;
	end
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_r <= phh_pkg::ST_IDLE;
			clr_a_r <= '0;
			{hv_r, hv2_r, clr_r, rdv_r} <= 4'h0;
			run_r <= 1'(phh_pkg::RUN_RST);
			ha_r <= '0;
			ha2_r <= '0;
			rq_r <= '0;
			rdd_r <= '0;
		end else if (CE) begin
			st_r <= st_nxt;
			clr_a_r <= clr_a_nxt;
			run_r <= run_nxt;
			clr_r <= (st_nxt == phh_pkg::ST_CLEAR);
			hv_r <= hv_nxt;
			hv2_r <= hv_r;
			ha_r <= ha_nxt;
			ha2_r <= ha_r;
			rq_r <= rq_nxt;
			rdv_r <= RD_EN;
			rdd_r <= rdd_nxt;
			if (wr_en)
				mem[wr_a] <= wr_d;
		end
	end
	assign RUNNING = run_r;
	assign CLEARING = clr_r;
	assign INHIBIT = inh_r;
	assign RD_VALID = rdv_r;
	assign RD_DATA = rdd_r;

	sequence s_accepted;
		pa_r && st_r == phh_pkg::ST_RUN;
	endsequence
	sequence s_bin_written;
		##2 (wr_en && wr_a == $past(ha_nxt, 2));
	endsequence
	p_inc: assert property (s_accepted |-> s_bin_written)
		else $error("accepted peak not binned");
	p_sat: assert property (hv2_r && !clr_r && st_r != phh_pkg::ST_CLEAR
		&& rq_r == phh_pkg::CNT_MAX |-> wr_d == phh_pkg::CNT_MAX)
		else $error("counter wrapped");
	p_inc_val: assert property (hv2_r && st_r != phh_pkg::ST_CLEAR
		&& rq_r != phh_pkg::CNT_MAX |-> wr_d == rq_r + 24'h000001)
		else $error("counter not incremented by one");
	p_stop: assert property (st_r == phh_pkg::ST_RUN && CMD.stop && !CMD.clear
		|=> !run_r ##1 !run_r)
		else $error("stop not honoured");
	p_clear_end: assert property (st_r == phh_pkg::ST_CLEAR
		&& clr_a_r == LAST_A |=> st_r == phh_pkg::ST_IDLE && !run_r)
		else $error("clear sweep did not end");
endmodule : phh_top

// ---- test/phh_adc_model.sv ----
// Converter model feeding the histogrammer one sample every second clock
`timescale 1ns/1ps
module phh_adc_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Level to digitize
	input wire logic [phh_pkg::SMP_W-1:0] level,
	// Sample stream
	output logic adc_valid,
	output logic [phh_pkg::SMP_W-1:0] adc_data
);
	logic phase_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_r <= 1'b0;
			adc_valid <= 1'b0;
			adc_data <= '0;
		end else begin
			phase_r <= ~phase_r;
			adc_valid <= phase_r;
			// Off-sample cycles show garbage, never the held value
			adc_data <= phase_r ? level : ~adc_data;
		end
	end
endmodule : phh_adc_model

// ---- test/phh_top_tb.sv ----
// Self-checking bench of the pulse height histogrammer
`timescale 1ns/1ps
module phh_top_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic adc_valid, preamp_reset = 1'b0, rd_en = 1'b0;
	logic [phh_pkg::SMP_W-1:0] adc_data, level = 12'h100;
	phh_pkg::phh_cfg_t cfg = '{5'h10, 5'h04, 1'b1, 6'h00, 17'h00100, 12'h040};
	phh_pkg::phh_cmd_t cmd = '0;
	logic [9:0] rd_addr = '0;
	logic [phh_pkg::SHP_W-1:0] shaped, peak_val;
	logic peak_valid, peak_accept, running, clearing, inhibit, rd_valid;
	logic [phh_pkg::CNT_W-1:0] rd_data;
	logic acc;
	logic [phh_pkg::SHP_W-1:0] pv;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;

	always #12.5 clk = ~clk;

	phh_adc_model adc_u (.clk(clk), .rstn(rstn), .level(level),
		.adc_valid(adc_valid), .adc_data(adc_data));

	phh_top #(.ADDR_W(10), .RECOV_CYC(4)) dut_u (.CLK(clk), .RSTN(rstn),
		.CE(1'b1), .ADC_VALID(adc_valid), .ADC_DATA(adc_data),
		.PREAMP_RESET(preamp_reset), .CFG(cfg), .CMD(cmd), .RD_EN(rd_en),
		.RD_ADDR(rd_addr), .SHAPED(shaped), .PEAK_VALID(peak_valid),
		.PEAK_ACCEPT(peak_accept), .PEAK_VAL(peak_val), .RUNNING(running),
		.CLEARING(clearing), .INHIBIT(inhibit), .RD_VALID(rd_valid),
		.RD_DATA(rd_data));

	task automatic report_and_stop;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic send_cmd(input phh_pkg::phh_cmd_t c);
		@(posedge clk);
		cmd <= c;
		@(posedge clk);
		cmd <= '0;
		#1;
	endtask : send_cmd

	task automatic rd_check(input logic [9:0] a, input logic [23:0] exp);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		check(rd_valid, 1);
		check(rd_data, exp);
	endtask : rd_check

	// One step (two if gap > 0) then one peak report expected
	task automatic pulse(input int gap);
		int n;
		n = 0;
		@(posedge clk);
		level <= level + 12'h080;
		if (gap > 0) begin
			repeat (gap) @(posedge clk);
			level <= level + 12'h080;
		end
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			#1;
			if (peak_valid === 1'b1) begin
				n++;
				acc = peak_accept;
				pv = peak_val;
			end
		end
		check(n, 1);
	endtask : pulse

	task automatic t_reset;
		check({running, clearing, inhibit, peak_valid}, 0);
		check(shaped, 0);
	endtask : t_reset

	task automatic t_clear;
		send_cmd(3'b001);
		check(clearing, 1);
		tick(1023);
		check(clearing, 1);
		tick(1);
		check(clearing, 0);
		rd_check(10'h010, 24'h000000);
	endtask : t_clear

	task automatic t_accept;
		send_cmd(3'b100);
		check(running, 1);
		pulse(0);
		check(acc, 1);
		check(pv, 18'h00800);
		rd_check(10'h010, 24'h000001);
		rd_check(10'h011, 24'h000000);
	endtask : t_accept

	task automatic t_peaking;
		@(posedge clk);
		cfg.rise <= 5'h08;
		tick(20);
		pulse(0);
		check(pv, 18'h00400);
		rd_check(10'h008, 24'h000001);
		@(posedge clk);
		cfg.rise <= 5'h10;
		tick(20);
	endtask : t_peaking

	task automatic t_stop;
		send_cmd(3'b010);
		check(running, 0);
		pulse(0);
		check(acc, 0);
		rd_check(10'h010, 24'h000001);
		send_cmd(3'b100);
	endtask : t_stop

	task automatic t_inhibit;
		@(posedge clk);
		preamp_reset <= 1'b1;
		tick(10);
		check(inhibit, 1);
		pulse(0);
		check(acc, 0);
		@(posedge clk);
		preamp_reset <= 1'b0;
		tick(3);
		check(inhibit, 1);
		tick(20);
		check(inhibit, 0);
	endtask : t_inhibit

	task automatic t_select;
		// Second step lands 34 clocks later, inside the pile-up interval
		pulse(34);
		check(acc, 0);
		@(posedge clk);
		cfg.rtd_max <= 6'h01;
		pulse(0);
		check(acc, 0);
		@(posedge clk);
		cfg.rtd_max <= 6'h00;
		rd_check(10'h010, 24'h000001);
	endtask : t_select

	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		tick(1);
		t_reset();
		t_clear();
		t_accept();
		t_peaking();
		t_stop();
		t_inhibit();
		t_select();
		report_and_stop();
	end
endmodule : phh_top_tb
